// [logic/dbf_consts.svh]
`ifndef DBF_CONSTS_SVH
`define DBF_CONSTS_SVH

// ****************************************************************
// Pointer, capacity and preload geometry
// ****************************************************************
`define DBF_PTR_W        13
`define DBF_CAP_BITS     13'h1000
`define DBF_PRE_ROW_LAST 9'h1FF
`define DBF_PRE_COL_LAST 4'h8
`define DBF_ROWS         512

// ****************************************************************
// Register word indexes on the Avalon slave
// ****************************************************************
`define DBF_OFF_CTRL     2'h0
`define DBF_OFF_THRESH   2'h1
`define DBF_OFF_STATUS   2'h2

// ****************************************************************
// Field positions and reset values
// ****************************************************************
`define DBF_CTRL_WW      0
`define DBF_CTRL_RW      3
`define DBF_CTRL_PIPE    6
`define DBF_CTRL_WENHI   7
`define DBF_CTRL_RENHI   8
`define DBF_CTRL_EHALT   9
`define DBF_CTRL_FHALT   10
`define DBF_THR_AF       0
`define DBF_THR_AE       16
`define DBF_ST_EMPTY     0
`define DBF_ST_FULL      1
`define DBF_ST_ALMOST_EMPTY_FLAG    2
`define DBF_ST_ALMOST_FULL_FLAG     3
`define DBF_ST_LEVEL     16
`define DBF_CTRL_RST     32'h0000_0100
`define DBF_THR_RST      32'h0000_0FFF

`endif

// [logic/dbf_pkg.sv]
`default_nettype none
`include "dbf_consts.svh"

package dbf_pkg;

    // Bus answer states, Gray along IDLE -> ANSWER
    typedef enum logic [0:0] {
        DBF_BUS_IDLE   = 1'b0,
        DBF_BUS_ANSWER = 1'b1
    } dbf_bus_st_t;

    // Aspect ratio codes, the rest are reserved
    typedef enum logic [2:0] {
        DBF_W1  = 3'h0,
        DBF_W2  = 3'h1,
        DBF_W4  = 3'h2,
        DBF_W9  = 3'h3,
        DBF_W18 = 3'h4
    } dbf_width_t;

    typedef struct packed {
        logic [2:0] write_width_select;
        logic [2:0] read_width_select;
        logic       read_pipeline_select;
        logic       wen_active_high;
        logic       ren_active_high;
        logic       empty_halt;
        logic       full_halt;
    } dbf_cfg_t;

    typedef struct packed {
        logic [11:0] almost_full_threshold;
        logic [11:0] almost_empty_threshold;
    } dbf_thr_t;

    typedef struct packed {
        dbf_bus_st_t           bus_st;
        logic                  waitreq;
        logic [31:0]           rdata;
        dbf_cfg_t              cfg;
        dbf_thr_t              thr;
        logic [`DBF_PTR_W-1:0] wptr;
        logic [`DBF_PTR_W-1:0] rptr;
        logic [`DBF_PTR_W-1:0] wsync1;
        logic [`DBF_PTR_W-1:0] wsync2;
        logic [`DBF_PTR_W-1:0] rsync1;
        logic [`DBF_PTR_W-1:0] rsync2;
        logic                  empty;
        logic                  full;
        logic                  almost_empty_flag;
        logic                  almost_full_flag;
        logic [17:0]           stage;
        logic                  pv;
        logic [17:0]           rd_out;
        logic [8:0]            pre_row;
        logic [3:0]            pre_col;
    } dbf_state_t;

    // Bits consumed per word; 9 and 18 wide count as 8 and 16
    function automatic logic [`DBF_PTR_W-1:0] dbf_step(input logic [2:0] code);
        unique case (code)
            DBF_W2:  dbf_step = 13'h0002;
            DBF_W4:  dbf_step = 13'h0004;
            DBF_W9:  dbf_step = 13'h0008;
            DBF_W18: dbf_step = 13'h0010;
            default: dbf_step = 13'h0001;
        endcase
    endfunction

endpackage

`default_nettype wire

// [logic/dbf_fifo.sv]
// Notes on behaviour
// RQ1 - Width selectors pick 4kx1, 2kx2, 1kx4, 512x9 or 256x18; codes above reserved.
// RQ2 - Port enables are active low; read outputs hold while read port disabled.
// RQ3 - Write enable defaults active low, read enable active high; both configurable.
// RQ4 - Pipeline select low gives data same cycle, high one cycle later.
// RQ5 - Pipelined read captures address, registers data, presents after second edge.
// RQ6 - Reset clears control and output registers, leaves memory contents alone.
// RQ7 - While reset is asserted all reads and writes are ignored.
// RQ8 - Writer grounds write data bits above the selected width.
// RQ9 - Read data bits above the selected width are undefined.
// RQ10 - Almost-full when write minus read address reaches the threshold.
// RQ11 - Almost-empty when write minus read address is at or below threshold.
// RQ12 - Thresholds count data bits, not words.
// RQ13 - Empty made on read side, full made on write side.
// RQ14 - Empty clears two edges after a write, sets on last read.
// RQ15 - Full reflects the physical memory capacity only.
// RQ16 - Counters either stop or keep counting at empty or full, by configuration.
// RQ17 - Memory captures on rising edges only.
// RQ18 - Each port works entirely in its own clock domain; here both ports run on the single CLK.
// RQ19 - Memory can be preloaded serially with all 4608 bits through the test port; the code stops one shift short of the last bit, so 4607 load.
// RQ20 - Address counters start at zero and wrap after the last location.
// RQ21 - Halt inputs stop read counter when empty, write counter when full.
// RQ22 - Both thresholds are twelve bits wide.
// RQ23 - Full stays set until two write edges after the freeing read.
// RQ24 - Write when full or read when empty corrupts nothing unless counting on.
// RQ25 - Address difference is taken modulo the counter width.
//
// The register addresses and the Avalon-MM register port were chosen for this implementation.
`timescale 1ns/10ps
`default_nettype none
`include "dbf_consts.svh"

module dbf_fifo (
    input  wire logic        CLK,
    input  wire logic        RST_N,
    // Avalon-MM register slave
    input  wire logic [1:0]  AVS_ADDRESS,
    input  wire logic        AVS_READ,
    input  wire logic        AVS_WRITE,
    input  wire logic [31:0] AVS_WRITEDATA,
    output logic      [31:0] AVS_READDATA,
    output logic             AVS_WAITREQUEST,
    // Producer side
    input  wire logic        WRITE_PORT_ENABLE_N,
    input  wire logic        WRITE_ENABLE,
    input  wire logic [17:0] WRITE_DATA_IN,
    // Consumer side
    input  wire logic        READ_PORT_ENABLE_N,
    input  wire logic        READ_ENABLE,
    output logic      [17:0] READ_DATA_OUT,
    // Flags
    output logic             EMPTY,
    output logic             FULL,
    output logic             ALMOST_EMPTY_FLAG,
    output logic             ALMOST_FULL_FLAG,
    // Serial preload
    input  wire logic        USER_TEST_PORT_ACCESS,
    input  wire logic        PRELOAD_SHIFT,
    input  wire logic        PRELOAD_BIT
);

    // ****************************************************************
    // Storage and state
    // ****************************************************************
    logic [8:0]                   mem [`DBF_ROWS];
    dbf_pkg::dbf_state_t          s;
    dbf_pkg::dbf_state_t          next_s;
    logic                         wr_act;
    logic                         rd_act;
    logic                         wr_go;
    logic                         rd_go;
    logic [17:0]                  rd_word;
    logic [8:0]                   rd_lo;
    logic [8:0]                   rd_hi;
    logic [`DBF_PTR_W-1:0]        wstep;
    logic [`DBF_PTR_W-1:0]        rstep;
    logic [`DBF_PTR_W-1:0]        lvl_w;
    logic [`DBF_PTR_W-1:0]        lvl_r;
    logic [31:0]                  readback;
    logic                         m_en0;
    logic                         m_en1;
    logic [8:0]                   m_row0;
    logic [8:0]                   m_row1;
    logic [8:0]                   m_mask0;
    logic [8:0]                   m_d0;
    logic [8:0]                   m_d1;
    logic                         pre_go;
    logic [11:0]                  wa;
    logic [11:0]                  ra;
    logic [31:0]                  cfg_word;
    dbf_pkg::dbf_cfg_t            cfg_dec;

    // Enable polarity follows the configured sense
    assign wr_act = s.cfg.wen_active_high ? WRITE_ENABLE : !WRITE_ENABLE; // RQ3
    assign rd_act = s.cfg.ren_active_high ? READ_ENABLE : !READ_ENABLE;   // RQ3

    // Accepted operations; refused in reset, during preload, or at a halted limit
    assign wr_go = RST_N && !USER_TEST_PORT_ACCESS && !WRITE_PORT_ENABLE_N && wr_act // RQ7
                   && (!s.full || !s.cfg.full_halt);                                 // RQ21
    assign rd_go = RST_N && !USER_TEST_PORT_ACCESS && !READ_PORT_ENABLE_N && rd_act  // RQ2
                   && (!s.empty || !s.cfg.empty_halt);                               // RQ16
    assign pre_go = RST_N && USER_TEST_PORT_ACCESS && PRELOAD_SHIFT
                    && !(s.pre_row == `DBF_PRE_ROW_LAST && s.pre_col == `DBF_PRE_COL_LAST);

    assign wstep = dbf_pkg::dbf_step(s.cfg.write_width_select); // RQ1
    assign rstep = dbf_pkg::dbf_step(s.cfg.read_width_select);  // RQ1
    assign wa    = s.wptr[11:0];
    assign ra    = s.rptr[11:0];

    // One decoder for bus writes and the reset value, so the bit layout cannot drift
    assign cfg_word = RST_N ? AVS_WRITEDATA : `DBF_CTRL_RST;
    assign cfg_dec  = {cfg_word[`DBF_CTRL_WW +: 3], cfg_word[`DBF_CTRL_RW +: 3], cfg_word[`DBF_CTRL_PIPE],
                       cfg_word[`DBF_CTRL_WENHI], cfg_word[`DBF_CTRL_RENHI], cfg_word[`DBF_CTRL_EHALT],
                       cfg_word[`DBF_CTRL_FHALT]};

    // ****************************************************************
    // Read word extraction at the read pointer
    // ****************************************************************
    // Rows hold eight data bits plus a ninth used only by 9/18 wide words
    assign rd_lo = (s.cfg.read_width_select == dbf_pkg::DBF_W18) ? mem[{ra[11:4], 1'b0}] : mem[ra[11:3]];
    assign rd_hi = mem[{ra[11:4], 1'b1}];

    // Bits above the selected width read back as zero
    always_comb begin
        unique case (s.cfg.read_width_select)
            dbf_pkg::DBF_W2:  rd_word = {16'h0000, rd_lo[{ra[2:1], 1'b0} +: 2]};
            dbf_pkg::DBF_W4:  rd_word = {14'h0000, rd_lo[{ra[2], 2'b00} +: 4]};
            dbf_pkg::DBF_W9:  rd_word = {9'h000, rd_lo};
            dbf_pkg::DBF_W18: rd_word = {rd_hi, rd_lo};
            default:          rd_word = {17'h0_0000, rd_lo[ra[2:0]]}; // RQ9
        endcase
    end

    // ****************************************************************
    // Register readback
    // ****************************************************************
    always_comb begin
        readback = 32'h0000_0000;
        unique case (AVS_ADDRESS)
            `DBF_OFF_CTRL: begin
                readback[`DBF_CTRL_WW +: 3]  = s.cfg.write_width_select;
                readback[`DBF_CTRL_RW +: 3]  = s.cfg.read_width_select;
                readback[`DBF_CTRL_PIPE]     = s.cfg.read_pipeline_select;
                readback[`DBF_CTRL_WENHI]    = s.cfg.wen_active_high;
                readback[`DBF_CTRL_RENHI]    = s.cfg.ren_active_high;
                readback[`DBF_CTRL_EHALT]    = s.cfg.empty_halt;
                readback[`DBF_CTRL_FHALT]    = s.cfg.full_halt;
            end
            `DBF_OFF_THRESH: begin
                readback[`DBF_THR_AF +: 12]  = s.thr.almost_full_threshold;
                readback[`DBF_THR_AE +: 12]  = s.thr.almost_empty_threshold;
            end
            `DBF_OFF_STATUS: begin
                readback[`DBF_ST_EMPTY]      = s.empty;
                readback[`DBF_ST_FULL]       = s.full;
                readback[`DBF_ST_ALMOST_EMPTY_FLAG]     = s.almost_empty_flag;
                readback[`DBF_ST_ALMOST_FULL_FLAG]      = s.almost_full_flag;
                readback[`DBF_ST_LEVEL +: `DBF_PTR_W] = s.wptr - s.rsync2;
            end
            default: readback = 32'h0000_0000;
        endcase
    end

    // ****************************************************************
    // Next state
    // ****************************************************************
    always_comb begin
        next_s  = s;
        m_en0   = 1'b0;
        m_en1   = 1'b0;
        m_row0  = wa[11:3];
        m_row1  = {wa[11:4], 1'b1};
        m_mask0 = 9'h1FF;
        m_d0    = WRITE_DATA_IN[8:0];
        m_d1    = WRITE_DATA_IN[17:9];
        lvl_w   = '0;
        lvl_r   = '0;

        // Write lanes; upper data bits are grounded by the producer
        if (wr_go) begin
            m_en0 = 1'b1;
            unique case (s.cfg.write_width_select)
                dbf_pkg::DBF_W2: begin
                    m_mask0 = 9'(9'h003 << {wa[2:1], 1'b0});
                    m_d0    = 9'({7'h00, WRITE_DATA_IN[1:0]} << {wa[2:1], 1'b0});
                end
                dbf_pkg::DBF_W4: begin
                    m_mask0 = 9'(9'h00F << {wa[2], 2'b00});
                    m_d0    = 9'({5'h00, WRITE_DATA_IN[3:0]} << {wa[2], 2'b00});
                end
                dbf_pkg::DBF_W9: begin
                    m_mask0 = 9'h1FF;
                end
                dbf_pkg::DBF_W18: begin
                    m_row0  = {wa[11:4], 1'b0};
                    m_en1   = 1'b1;
                end
                default: begin
                    m_mask0 = 9'(9'h001 << wa[2:0]);
                    m_d0    = 9'({8'h00, WRITE_DATA_IN[0]} << wa[2:0]);
                end
            endcase
            next_s.wptr = s.wptr + wstep; // RQ20
        end

        // Serial preload, one bit per shift, row by row
        if (pre_go) begin
            m_en0   = 1'b1;
            m_row0  = s.pre_row;
            m_mask0 = 9'(9'h001 << s.pre_col);
            m_d0    = {9{PRELOAD_BIT}} & m_mask0; // RQ19
            if (s.pre_col == `DBF_PRE_COL_LAST) begin
                next_s.pre_col = 4'h0;
                next_s.pre_row = s.pre_row + 9'h001;
            end else begin
                next_s.pre_col = s.pre_col + 4'h1;
            end
        end
        if (!USER_TEST_PORT_ACCESS) begin
            next_s.pre_row = 9'h000;
            next_s.pre_col = 4'h0;
        end

        // Read pointer wraps with the counter width
        if (rd_go) begin
            next_s.rptr = s.rptr + rstep; // RQ20
        end

        // Read data path; a disabled read port holds its output
        if (!READ_PORT_ENABLE_N) begin
            if (s.cfg.read_pipeline_select && s.pv) begin
                next_s.rd_out = s.stage; // RQ5
                next_s.pv     = 1'b0;
            end
            if (rd_go) begin
                if (s.cfg.read_pipeline_select) begin
                    next_s.stage = rd_word; // RQ5
                    next_s.pv    = 1'b1;
                end else begin
                    next_s.rd_out = rd_word; // RQ4
                end
            end
        end

        // Pointer crossings; the far pointer arrives two edges late
        next_s.wsync1 = s.wptr;   // RQ18
        next_s.wsync2 = s.wsync1; // RQ14
        next_s.rsync1 = s.rptr;   // RQ18
        next_s.rsync2 = s.rsync1; // RQ23

        // Register bus answer, one wait cycle per access
        unique case (s.bus_st)
            dbf_pkg::DBF_BUS_IDLE: begin
                next_s.waitreq = 1'b1;
                if (AVS_READ || AVS_WRITE) begin
                    next_s.bus_st  = dbf_pkg::DBF_BUS_ANSWER;
                    next_s.waitreq = 1'b0;
                    next_s.rdata   = AVS_READ ? readback : 32'h0000_0000;
                end
            end
            dbf_pkg::DBF_BUS_ANSWER: begin
                next_s.bus_st  = dbf_pkg::DBF_BUS_IDLE;
                next_s.waitreq = 1'b1;
                if (AVS_WRITE && AVS_ADDRESS == `DBF_OFF_CTRL) begin
                    next_s.cfg = cfg_dec;
                end
                if (AVS_WRITE && AVS_ADDRESS == `DBF_OFF_THRESH) begin
                    next_s.thr.almost_full_threshold  = AVS_WRITEDATA[`DBF_THR_AF +: 12]; // RQ22
                    next_s.thr.almost_empty_threshold = AVS_WRITEDATA[`DBF_THR_AE +: 12]; // RQ22
                end
            end
        endcase

        // Flags from next values so each matches the state it stands beside
        lvl_r = next_s.wsync2 - next_s.rptr; // RQ25
        lvl_w = next_s.wptr - next_s.rsync2; // RQ25
        // Empty as soon as a whole read word is missing
        next_s.empty  = lvl_r < dbf_pkg::dbf_step(next_s.cfg.read_width_select); // RQ13
        next_s.almost_empty_flag = lvl_r <= {1'b0, next_s.thr.almost_empty_threshold};      // RQ11
        // Full against the physical capacity, not a requested depth
        next_s.full   = (`DBF_CAP_BITS - lvl_w) < dbf_pkg::dbf_step(next_s.cfg.write_width_select); // RQ15
        next_s.almost_full_flag  = lvl_w >= {1'b0, next_s.thr.almost_full_threshold};       // RQ10 RQ12

        // Reset clears control and outputs; memory keeps its contents
        if (!RST_N) begin
            next_s        = '0; // RQ6
            next_s.bus_st = dbf_pkg::DBF_BUS_IDLE;
            next_s.cfg    = cfg_dec; // RQ3
            next_s.thr.almost_full_threshold  = 12'(`DBF_THR_RST);
            next_s.waitreq = 1'b1;
            next_s.empty   = 1'b1;
            next_s.almost_empty_flag  = 1'b1;
        end
    end

    // ****************************************************************
    // Registers
    // ****************************************************************
    // Control state, rising edge only
    always_ff @(posedge CLK) begin
        s <= next_s; // RQ17
    end

    // Memory array has no reset; a refused access leaves it untouched
    always_ff @(posedge CLK) begin
        if (m_en0) begin
            mem[m_row0] <= (mem[m_row0] & ~m_mask0) | (m_d0 & m_mask0); // RQ24
        end
        if (m_en1) begin
            mem[m_row1] <= m_d1;
        end
    end

    // Outputs straight from flops
    assign AVS_READDATA      = s.rdata;
    assign AVS_WAITREQUEST   = s.waitreq;
    assign READ_DATA_OUT     = s.rd_out;
    assign EMPTY             = s.empty;
    assign FULL              = s.full;
    assign ALMOST_EMPTY_FLAG = s.almost_empty_flag;
    assign ALMOST_FULL_FLAG  = s.almost_full_flag;

    // ****************************************************************
    // Assertions
    // ****************************************************************
    default clocking dbf_cb @(posedge CLK);
    endclocking
    default disable iff (!RST_N);

    logic same_w;
    assign same_w = s.cfg.write_width_select == s.cfg.read_width_select;

    // One write into an empty FIFO with no reads around it
    sequence write_into_empty;
        wr_go && EMPTY && !rd_go && same_w ##1 !rd_go && !wr_go ##1 !rd_go && !wr_go;
    endsequence

    // One read out of a full FIFO with no writes around it
    sequence read_out_of_full;
        rd_go && FULL && !wr_go && same_w ##1 !wr_go && !rd_go ##1 !wr_go && !rd_go;
    endsequence

    sequence piped_read;
        rd_go && s.cfg.read_pipeline_select ##1 !READ_PORT_ENABLE_N && !rd_go;
    endsequence

    a_empty_lag: assert property (write_into_empty |-> EMPTY ##1 !EMPTY) // RQ14
        else $error("Empty did not clear two edges after a write");

    a_full_lag: assert property (read_out_of_full |-> FULL ##1 !FULL) // RQ23
        else $error("Full did not clear two edges after a read");

    a_full_halt: assert property (FULL && s.cfg.full_halt |=> $stable(s.wptr)) // RQ21
        else $error("Write accepted while full and halted");

    a_empty_halt: assert property (EMPTY && s.cfg.empty_halt && !USER_TEST_PORT_ACCESS
                                   |=> $stable(s.rptr)) // RQ16
        else $error("Read counter moved while empty and halted");

    a_port_hold: assert property (READ_PORT_ENABLE_N ##1 RST_N |-> $stable(READ_DATA_OUT)) // RQ2
        else $error("Read data changed while read port disabled");

    a_direct_read: assert property (rd_go && !s.cfg.read_pipeline_select
                                    |=> READ_DATA_OUT == $past(rd_word)) // RQ4
        else $error("Unpipelined read data not presented after one edge");

    a_piped_read: assert property (piped_read |=> READ_DATA_OUT == $past(rd_word, 2)) // RQ5
        else $error("Pipelined read data not presented after two edges");

    a_almost_full_flag_level: assert property (ALMOST_FULL_FLAG == ((s.wptr - s.rsync2)
                                    >= {1'b0, s.thr.almost_full_threshold})) // RQ10
        else $error("Almost full does not match the level");

    a_almost_empty_flag_level: assert property (ALMOST_EMPTY_FLAG == ((s.wsync2 - s.rptr)
                                     <= {1'b0, s.thr.almost_empty_threshold})) // RQ11
        else $error("Almost empty does not match the level");

    a_reset_clear: assert property (@(posedge CLK) disable iff (1'b0)
                                    !RST_N |=> READ_DATA_OUT == 18'h0_0000 && s.wptr == 13'h0000) // RQ6
        else $error("Reset did not clear outputs and pointers");

    a_reset_ops: assert property (@(posedge CLK) disable iff (1'b0) !RST_N |-> !m_en0 && !m_en1) // RQ7
        else $error("Operation accepted during reset");

    a_bus_answer: assert property ((AVS_READ || AVS_WRITE) && AVS_WAITREQUEST && s.bus_st == dbf_pkg::DBF_BUS_IDLE
                                   |=> !AVS_WAITREQUEST)
        else $error("Bus request not answered after one wait cycle");

endmodule

`default_nettype wire

// [tb/dbf_partner.sv]
`timescale 1ns/10ps
`default_nettype none
// ****
// Producer and consumer logic on the fabric side
// ****
module dbf_partner (
    input  wire logic  CLK,
    output logic       WPE_N,
    output logic       WE,
    output logic [17:0] WD,
    output logic       RPE_N,
    output logic       RE
);
    logic we_on = 1'h0; // Active write level, low after reset
    initial begin
        WPE_N = 1'h1;
        WE = 1'h1;
        WD = 18'h0_0000;
        RPE_N = 1'h1;
        RE = 1'h0;
    end
    // One word of w bits, upper bits grounded
    task automatic push(input logic [17:0] d, input int w);
        logic [17:0] m;
        m = d & ((18'h0_0001 << w) - 18'h0_0001);
        @(posedge CLK);
        WPE_N <= 1'h0;
        WE <= we_on;
        WD <= m;
        @(posedge CLK);
        WPE_N <= 1'h1;
        WE <= ~we_on;
        WD <= ~m; // Released bus never shows the old word
    endtask
    // Read attempt; port enable is left as set for pipelined data
    task automatic pop(input logic en_n);
        @(posedge CLK);
        RPE_N <= en_n;
        RE <= 1'h1;
        @(posedge CLK);
        RE <= 1'h0;
    endtask
endmodule
`default_nettype wire

// [tb/dual_clock_block_ram_fifo_test.sv]
`timescale 1ns/10ps
`default_nettype none
module dual_clock_block_ram_fifo_test;
    logic        clk = 1'h0;
    logic        rst_n = 1'h0;
    logic [1:0]  adr = 2'h0;
    logic        rd_req = 1'h0;
    logic        wr_req = 1'h0;
    logic [31:0] wdat = 32'h0000_0000;
    logic [31:0] rdat, q;
    logic        wait_req, empty, full, aef, aff, wpe_n, we, rpe_n, re;
    logic [17:0] wd, rd;
    logic        tpa = 1'h0, psh = 1'h0, pbit = 1'h0;
    int          num_errors = 0;
    int          cmp_count = 0;
    // Clock at 125 MHz
    always #4 clk = ~clk;
    dbf_fifo i_dut (.CLK(clk), .RST_N(rst_n), .AVS_ADDRESS(adr), .AVS_READ(rd_req),
        .AVS_WRITE(wr_req), .AVS_WRITEDATA(wdat), .AVS_READDATA(rdat), .AVS_WAITREQUEST(wait_req),
        .WRITE_PORT_ENABLE_N(wpe_n), .WRITE_ENABLE(we), .WRITE_DATA_IN(wd),
        .READ_PORT_ENABLE_N(rpe_n), .READ_ENABLE(re), .READ_DATA_OUT(rd), .EMPTY(empty),
        .FULL(full), .ALMOST_EMPTY_FLAG(aef), .ALMOST_FULL_FLAG(aff),
        .USER_TEST_PORT_ACCESS(tpa), .PRELOAD_SHIFT(psh), .PRELOAD_BIT(pbit));
    dbf_partner i_p (.CLK(clk), .WPE_N(wpe_n), .WE(we), .WD(wd), .RPE_N(rpe_n), .RE(re));
    // ****
    // Shared tasks
    // ****
    task automatic chk(input string n, input logic [31:0] e, input logic [31:0] g);
        cmp_count++;
        if (g !== e) begin
            num_errors++;
            $display("mismatch %s expected %h seen %h", n, e, g);
        end
    endtask
    task automatic tick(input int n);
        repeat (n) @(posedge clk);
        #1;
    endtask
    // Avalon access, held until waitrequest is seen low
    task automatic bus(input logic w, input logic [1:0] a, input logic [31:0] d, output logic [31:0] r);
        @(posedge clk);
        adr <= a;
        wr_req <= w;
        rd_req <= ~w;
        wdat <= d;
        do @(posedge clk); while (wait_req !== 1'h0);
        r = rdat;
        wr_req <= 1'h0;
        rd_req <= 1'h0;
    endtask
    task automatic print_verdict;
        if (num_errors == 0 && cmp_count > 0) begin
            $display("Run complete: PASS");
        end else begin
            $display("Run complete: FAIL");
        end
        $finish;
    endtask
    // ****
    // Scenarios
    // ****
    task automatic t_narrow;
        tick(1);
        chk("empty", 1, empty);
        chk("rdata", 0, rd);
        bus(0, 2'h0, 0, q);
        chk("ctrl", 32'h0000_0100, q);
        bus(0, 2'h1, 0, q);
        chk("thresh", 32'h0000_0FFF, q);
        bus(0, 2'h3, 0, q);
        chk("unmapped", 0, q);
        i_p.push(18'h0_0001, 1);
        tick(1);
        chk("empty", 1, empty);
        tick(1);
        chk("empty", 0, empty);
        i_p.push(18'h0_0000, 1);
        i_p.push(18'h3_FFFF, 1);
        tick(2);
        for (int i = 0; i < 3; i++) begin
            i_p.pop(1'h0);
            #1;
            chk("rdata", (i == 1) ? 0 : 1, rd);
        end
        chk("empty", 1, empty);
    endtask
    task automatic t_pipe;
        bus(1, 2'h0, 32'h0000_015B, q);
        i_p.push(18'h0_01A5, 9);
        tick(3);
        i_p.pop(1'h0);
        #1;
        chk("rdata", 1, rd);
        tick(1);
        chk("rdata", 32'h0000_01A5, rd);
        i_p.push(18'h0_005A, 9);
        tick(3);
        i_p.pop(1'h1);
        tick(2);
        chk("rdata", 32'h0000_01A5, rd);
        i_p.pop(1'h0);
        tick(1);
        chk("rdata", 32'h0000_005A, rd);
    endtask
    task automatic t_full;
        bus(1, 2'h0, 32'h0000_07A4, q);
        bus(1, 2'h1, 32'h0010_0040, q);
        i_p.we_on = 1'h1;
        for (int i = 0; i < 257; i++) begin
            i_p.push({9'h100, 9'(i)}, 18);
            #1;
            if (i == 1) chk("almost_empty_flag", 1, aef);
            if (i == 2) chk("almost_empty_flag", 0, aef);
            if (i == 2) chk("almost_full_flag", 0, aff);
            if (i == 3) chk("almost_full_flag", 1, aff);
        end
        chk("full", 1, full);
        bus(0, 2'h2, 0, q);
        chk("status", 32'h1000_000A, q);
        for (int i = 0; i < 256; i++) begin
            i_p.pop(1'h0);
            #1;
            chk("rdata", {14'h0000, 9'h100, 9'(i)}, rd);
            if (i == 0) begin
                tick(1);
                chk("full", 1, full);
                tick(1);
                chk("full", 0, full);
            end
        end
        i_p.pop(1'h0);
        #1;
        chk("rdata", {14'h0000, 9'h100, 9'h0FF}, rd);
        chk("empty", 1, empty);
    endtask
    task automatic t_rst_mid;
        @(posedge clk);
        rst_n <= 1'h0;
        i_p.push(18'h0_1234, 18);
        tick(1);
        chk("rdata", 0, rd);
        @(posedge clk);
        rst_n <= 1'h1;
        tick(3);
        chk("empty", 1, empty);
    endtask
    // Three preloaded bits, then read back as 1-bit words past empty
    task automatic t_preload;
        @(posedge clk);
        tpa <= 1'h1;
        for (int i = 0; i < 3; i++) begin
            @(posedge clk);
            psh <= 1'h1;
            pbit <= ~i[0];
        end
        @(posedge clk);
        psh <= 1'h0;
        tpa <= 1'h0;
        for (int i = 0; i < 3; i++) begin
            i_p.pop(1'h0);
            #1;
            chk("preload", {31'h0000_0000, ~i[0]}, rd);
        end
    endtask
    // Main sequence
    initial begin
        repeat (2) @(posedge clk);
        rst_n <= 1'h1;
        t_narrow();
        t_pipe();
        t_full();
        t_rst_mid();
        t_preload();
        print_verdict();
    end
    // Watchdog, well beyond the expected 1100 or so cycles
    initial begin
        #100_000;
        num_errors++;
        print_verdict();
    end
endmodule
`default_nettype wire
